/* File: core/wss_top.sv */
// Purpose : stop mode wake source two selector with wishbone registers
// Assumes : rst_n_i is the power-on reset, pins synchronous to sys_clk_i
// Notes   : source one recovery arrives as wake_one_i
//
// Functional notes
// - select 000 gives no pin wake; only source one or power-on reset ends stop.
// - 001 is NAND of port 2 bits 0-3; 010 NAND of bits 0-7.
// - 011 is NOR of port 3 bits 1-3; 100 is their NAND.
// - 101 NOR of port 3 bits 1-3, port 0 bits 0,7; 110 NAND.
// - 111 is NAND of port 3 bits 1-3 and port 2 bits 0-2.
// - level bit D6 at xor: 0 wakes on low, 1 on high.
// - select and level bits are write-only; reads return zero.
// - either source one or source two ends stop mode.
// - pins configured as outputs are left out of the combination.
// - select resets to 000 at power-on, kept across stop recovery.
`timescale 1ns/100ps
module wss_top
	import wss_pkg::*;
(
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	// wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [SEL_W-1:0] wb_sel_i,
	input  wire logic [DAT_W-1:0] wb_dat_i,
	output logic      [DAT_W-1:0] wb_dat_o,
	output logic                  wb_ack_o,
	// core and pins
	input  wire logic             stop_req_i,
	input  wire logic             wake_one_i,
	input  wire wss_pins_t        pins_i,
	input  wire wss_pins_t        dir_out_i,
	output logic                  stopped_o,
	output logic                  restart_o
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		wss_state_t       state;
		logic [2:0]       sel;
		logic             level;
		logic             ack;
		logic [DAT_W-1:0] rdata;
		logic             restart;
		logic             by_two;
		logic             by_one;
		logic [7:0]       count;
		logic             stopped;
	} wss_regs_t;

	localparam wss_regs_t REGS_RESET = '{
		state:   ST_RUN,
		sel:     SEL_RESET,
		level:   LEVEL_RESET,
		ack:     1'b0,
		rdata:   32'h00000000,
		restart: 1'b0,
		by_two:  1'b0,
		by_one:  1'b0,
		count:   8'h00,
		stopped: 1'b0
	};

	wss_regs_t st_ff;
	wss_regs_t nxt_st;

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [ADR_W-1:0] a,
		input logic [7:0] idx);
		hit = (a[ADR_W-1:2] == idx[ADR_W-3:0]) && (a[1:0] == 2'h0);
	endfunction

	// ------------------------------------------------------------------
	// wake combination
	// ------------------------------------------------------------------
	logic two_active;

	wss_wake_combine u_combine (
		.sel_i     (st_ff.sel),
		.level_i   (st_ff.level),
		.pins_i    (pins_i),
		.dir_out_i (dir_out_i),
		.active_o  (two_active)
	);

	// ------------------------------------------------------------------
	// bus request
	// ------------------------------------------------------------------
	logic req;
	logic wr;
	logic rd;

	// one request per ack; ack drops the cycle after
	assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
	assign wr  = req && wb_we_i;
	assign rd  = req && !wb_we_i;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.ack     = req;
		nxt_st.restart = 1'b0;

		// register writes; reserved bits are discarded
		if (wr && wb_sel_i[0] && hit(wb_adr_i, IDX_SRC_TWO)) begin
			nxt_st.sel   = wb_dat_i[SEL_MSB:SEL_LSB];
			nxt_st.level = wb_dat_i[LEVEL_POS];
		end
		if (wr && wb_sel_i[0] && hit(wb_adr_i, IDX_COUNT)) begin
			nxt_st.count = 8'h00;
		end

		// register reads
		if (rd) begin
			nxt_st.rdata = 32'h00000000;
			if (hit(wb_adr_i, IDX_SRC_TWO)) begin
				// write-only control reads back zero
				nxt_st.rdata = 32'h00000000;
			end else if (hit(wb_adr_i, IDX_STATUS)) begin
				nxt_st.rdata[ST_STOPPED] = (st_ff.state == ST_STOP);
				nxt_st.rdata[ST_BY_TWO]  = st_ff.by_two;
				nxt_st.rdata[ST_BY_ONE]  = st_ff.by_one;
				nxt_st.rdata[ST_ACTIVE]  = two_active;
			end else if (hit(wb_adr_i, IDX_COUNT)) begin
				nxt_st.rdata[7:0] = st_ff.count;
			end
		end

		// stop and recovery sequencing
		unique case (st_ff.state)
			ST_RUN: begin
				if (stop_req_i) begin
					nxt_st.state  = ST_STOP;
					nxt_st.by_two = 1'b0;
					nxt_st.by_one = 1'b0;
				end
			end
			ST_STOP: begin
				// either source ends stop mode
				if (two_active || wake_one_i) begin
					nxt_st.state   = ST_WAKE;
					nxt_st.restart = 1'b1;
					nxt_st.by_two  = two_active;
					nxt_st.by_one  = wake_one_i;
					if (two_active && st_ff.count != 8'hFF) begin
						nxt_st.count = st_ff.count + 8'h01;
					end
				end
			end
			ST_WAKE: begin
				// selection kept, only the sequencer returns
				nxt_st.state = ST_RUN;
			end
			default: begin
				nxt_st.state = ST_RUN;
			end
		endcase

		// stop flag registered so stopped_o leaves a flop
		nxt_st.stopped = (nxt_st.state == ST_STOP);
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			// only power-on reset clears the selection
			st_ff <= REGS_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign wb_dat_o  = st_ff.rdata;
	assign wb_ack_o  = st_ff.ack;
	assign stopped_o = st_ff.stopped;
	assign restart_o = st_ff.restart;

endmodule

/* File: core/wss_pkg.sv */
// Purpose : shared constants and types of the stop wake source two selector
// Assumes : one 50 MHz clock, classic wishbone register bus
// Notes   : register indices are word indices, byte address is index * 4
package wss_pkg;

	// ------------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_SRC_TWO = 8'h0D;
	localparam logic [7:0] IDX_STATUS  = 8'h0E;
	localparam logic [7:0] IDX_COUNT   = 8'h0F;

	// ------------------------------------------------------------------
	// source two control fields
	// ------------------------------------------------------------------
	localparam int SEL_LSB   = 2;
	localparam int SEL_MSB   = 4;
	localparam int LEVEL_POS = 6;

	localparam logic [2:0] SEL_RESET   = 3'h0;
	localparam logic       LEVEL_RESET = 1'b0;

	// ------------------------------------------------------------------
	// status fields
	// ------------------------------------------------------------------
	localparam int ST_STOPPED = 0;
	localparam int ST_BY_TWO  = 1;
	localparam int ST_BY_ONE  = 2;
	localparam int ST_ACTIVE  = 3;

	// ------------------------------------------------------------------
	// select codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_POR_ONLY  = 3'h0,
		SRC_NAND_P2L  = 3'h1,
		SRC_NAND_P2   = 3'h2,
		SRC_NOR_P3    = 3'h3,
		SRC_NAND_P3   = 3'h4,
		SRC_NOR_P3P0  = 3'h5,
		SRC_NAND_P3P0 = 3'h6,
		SRC_NAND_P3P2 = 3'h7
	} wss_src_t;

	// ------------------------------------------------------------------
	// pin masks, layout {port3[3:1], port2[7:0], port0[7:0]}
	// ------------------------------------------------------------------
	localparam int PIN_W = 19;
	localparam logic [18:0] MSK_NONE = 19'h00000;
	localparam logic [18:0] MSK_P2L  = 19'h00F00;
	localparam logic [18:0] MSK_P2   = 19'h0FF00;
	localparam logic [18:0] MSK_P3   = 19'h70000;
	localparam logic [18:0] MSK_P3P0 = 19'h70081;
	localparam logic [18:0] MSK_P3P2 = 19'h70700;

	typedef struct packed {
		logic [3:1] port3;
		logic [7:0] port2;
		logic [7:0] port0;
	} wss_pins_t;

	// ------------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN  = 3'h1,
		ST_STOP = 3'h2,
		ST_WAKE = 3'h4
	} wss_state_t;

endpackage

/* File: core/wss_wake_combine.sv */
// Purpose : forms the source two wake condition from the port pins
// Assumes : pins synchronous to the clock, dir bit high means output
// Notes   : purely combinational
`timescale 1ns/100ps
module wss_wake_combine
	import wss_pkg::*;
(
	input  wire logic [2:0] sel_i,
	input  wire logic       level_i,
	input  wire wss_pins_t  pins_i,
	input  wire wss_pins_t  dir_out_i,
	output logic            active_o
);

	// ------------------------------------------------------------------
	// code decode
	// ------------------------------------------------------------------
	function automatic logic [18:0] code_mask(input logic [2:0] c);
		unique case (wss_src_t'(c))
			SRC_POR_ONLY:               code_mask = MSK_NONE;
			SRC_NAND_P2L:               code_mask = MSK_P2L;
			SRC_NAND_P2:                code_mask = MSK_P2;
			SRC_NOR_P3, SRC_NAND_P3:    code_mask = MSK_P3;
			SRC_NOR_P3P0, SRC_NAND_P3P0: code_mask = MSK_P3P0;
			SRC_NAND_P3P2:              code_mask = MSK_P3P2;
		endcase
	endfunction

	logic [18:0] pin_vec;
	logic [18:0] eff;
	logic [18:0] nand_in;
	logic [18:0] nor_in;
	logic        is_nor;
	logic        combined;

	assign pin_vec = pins_i;
	// output pins drop out of the combination
	assign eff     = code_mask(sel_i) & ~dir_out_i;
	assign is_nor  = (sel_i == SRC_NOR_P3) || (sel_i == SRC_NOR_P3P0);

	genvar g;
	generate
		for (g = 0; g < PIN_W; g++) begin : g_pin
			assign nand_in[g] = eff[g] ? pin_vec[g] : 1'b1;
			assign nor_in[g]  = eff[g] ? pin_vec[g] : 1'b0;
		end
	endgenerate

	assign combined = is_nor ? ~|nor_in : ~&nand_in;
	// xor stage: level 0 wakes on low, 1 on high
	assign active_o = (|eff) && ((combined ^ level_i) == 1'b0);

endmodule

/* File: tb/wss_top_asserts.sv */
// Purpose : port assertions of wss_top
// Assumes : one clock, synchronous active low reset
// Notes   : bound to every wss_top instance
`timescale 1ns/100ps
module wss_top_chk
	import wss_pkg::*;
(
	input wire logic             sys_clk_i,
	input wire logic             rst_n_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [DAT_W-1:0] wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             stop_req_i,
	input wire logic             wake_one_i,
	input wire logic             stopped_o,
	input wire logic             restart_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_run_stop;
		!stopped_o && !restart_o && stop_req_i;
	endsequence
	a_ack_next: assert property (s_take |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_src_rd_zero: assert property ((s_take ##0 (!wb_we_i &&
		wb_adr_i == 8'h34)) |=> wb_dat_o == 32'h0)
		else $error("source two read not zero");
	a_unmap_rd_zero: assert property ((s_take ##0 (!wb_we_i &&
		wb_adr_i == 8'h80)) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_stop_enter: assert property (s_run_stop |=> stopped_o)
		else $error("stop request not taken");
	a_wake_one: assert property (stopped_o && wake_one_i
		|=> restart_o && !stopped_o)
		else $error("source one did not wake");
	a_restart_back: assert property (restart_o
		|=> !restart_o && !stopped_o)
		else $error("restart pulse wrong");
	a_restart_cause: assert property ($rose(restart_o)
		|-> $past(stopped_o) && $fell(stopped_o))
		else $error("restart without stop");
endmodule
bind wss_top wss_top_chk wss_top_chk_inst (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .stop_req_i(stop_req_i),
	.wake_one_i(wake_one_i), .stopped_o(stopped_o),
	.restart_o(restart_o));

/* File: tb/wss_pin_env.sv */
// Purpose : far-side port pin levels and directions
// Assumes : bench changes levels just after a rising edge
// Notes   : dir bit high marks a pin as output
`timescale 1ns/100ps
module wss_pin_env
	import wss_pkg::*;
(
	input  wire wss_pins_t lvl_i,
	input  wire wss_pins_t dir_i,
	output wss_pins_t      pins_o,
	output wss_pins_t      dir_o
);
	assign pins_o = lvl_i;
	assign dir_o  = dir_i;
endmodule

/* File: tb/tb_wss_top.sv */
// Purpose : self-checking bench of wss_top
// Assumes : wishbone ack follows the taking edge
// Notes   : wake expectations from select table and level bit
`timescale 1ns/100ps
`define CHK(a, e) begin \
	checks_done++; \
	if ((a) !== (e)) begin \
		n_mismatch++; \
		$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
	end \
end
module tb_wss_top
	import wss_pkg::*;
;
	typedef struct packed {
		logic [7:0]  r;
		logic [18:0] p;
		logic [18:0] d;
		logic        e;
	} wss_case_t;
	logic             sys_clk_i = 0, rst_n_i = 0;
	logic             wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [ADR_W-1:0] wb_adr_i = 0;
	logic [SEL_W-1:0] wb_sel_i = 0;
	logic [DAT_W-1:0] wb_dat_i = 0, wb_dat_o, rd;
	logic             wb_ack_o, stopped_o, restart_o;
	logic             stop_req_i = 0, wake_one_i = 0;
	wss_pins_t        pins_i, dir_out_i;
	wss_pins_t        lvl = '1, dir = '0;
	int               n_mismatch = 0, checks_done = 0, n_two = 0;
	localparam wss_case_t CASES [15] = '{
		'{8'h40, 19'h00000, 19'h0, 1'h0}, '{8'h04, 19'h7FFFF, 19'h0, 1'h1},
		'{8'h04, 19'h7FEFF, 19'h0, 1'h0},
		'{8'h04, 19'h7FEFF, 19'h00100, 1'h1},
		'{8'h04, 19'h77FFF, 19'h0, 1'h1}, '{8'h08, 19'h77FFF, 19'h0, 1'h0},
		'{8'h0C, 19'h10000, 19'h0, 1'h1}, '{8'h4C, 19'h00000, 19'h0, 1'h1},
		'{8'h4C, 19'h00000, 19'h70000, 1'h0},
		'{8'h50, 19'h7FFFF, 19'h0, 1'h0}, '{8'h50, 19'h6FFFF, 19'h0, 1'h1},
		'{8'h54, 19'h00080, 19'h0, 1'h0}, '{8'h54, 19'h0FF7E, 19'h0, 1'h1},
		'{8'h18, 19'h70080, 19'h0, 1'h0}, '{8'h1C, 19'h70700, 19'h0, 1'h1}};
	wss_top wss_top_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_req_i(stop_req_i),
		.wake_one_i(wake_one_i), .pins_i(pins_i), .dir_out_i(dir_out_i),
		.stopped_o(stopped_o), .restart_o(restart_o));
	wss_pin_env wss_pin_env_inst (.lvl_i(lvl), .dir_i(dir),
		.pins_o(pins_i), .dir_o(dir_out_i));
	// ------------------------------------------------------------------
	// bus and stop tasks
	// ------------------------------------------------------------------
	task automatic wb_xfer(input logic w, input logic [7:0] a,
			input logic [7:0] d);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		do @(posedge sys_clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge sys_clk_i);
	endtask
	// stop, watch for a pin wake, then recover through source one
	task automatic try(input logic exp);
		int n, m;
		n = 0;
		m = 0;
		stop_req_i <= 1'h1;
		@(posedge sys_clk_i);
		stop_req_i <= 1'h0;
		@(posedge sys_clk_i);
		`CHK(stopped_o, 1'h1)
		repeat (6) begin
			@(posedge sys_clk_i);
			if (restart_o === 1'h1) n++;
		end
		wake_one_i <= 1'h1;
		@(posedge sys_clk_i);
		wake_one_i <= 1'h0;
		repeat (3) begin
			@(posedge sys_clk_i);
			if (restart_o === 1'h1) m++;
		end
		if (exp) n_two++;
		`CHK({n != 0, m != 0}, {exp, !exp})
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1'h1;
		@(posedge sys_clk_i);
		try(1'h0);
		foreach (CASES[i]) begin
			wb_xfer(1'h1, 8'h34, CASES[i].r);
			lvl <= CASES[i].p;
			dir <= CASES[i].d;
			try(CASES[i].e);
		end
		try(1'h1);
		wb_xfer(1'h0, 8'h38, 8'h0);
		`CHK(rd, (32'h1 << ST_BY_TWO) | (32'h1 << ST_ACTIVE))
		wb_xfer(1'h0, 8'h34, 8'h0);
		`CHK(rd, 32'h0)
		wb_xfer(1'h0, 8'h3C, 8'h0);
		`CHK(rd, n_two)
		wb_xfer(1'h1, 8'h3C, 8'h0);
		wb_xfer(1'h0, 8'h3C, 8'h0);
		`CHK(rd, 32'h0)
		wb_xfer(1'h1, 8'h80, 8'hFF);
		wb_xfer(1'h0, 8'h80, 8'h0);
		`CHK(rd, 32'h0)
		wrap_up();
	end
endmodule
